// [ccrg_top.v]
// chip control register group: timer, chip control, debugger trap unit, irq source, ps/2 port
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_map.vh"
// How it works
// - 16-bit timer count, low byte at B1h, high byte at B2h, both read/write.
// - 8-bit read/write prescaler divisor ahead of the timer count.
// - low control bit 0 lets a debug trap also raise the serial interrupt.
// - low control bit 1 replaces ROM fetch data with a no-operation opcode.
// - low control bit 2 drives the internal memory address onto port pins.
// - high control bits 0-5 enable six units individually.
// - high control bits 6-7 give zero to three ROM wait states.
// - debugger registers reached by an index register and a data port.
// - debugger index 00 write sets the trap enables and single step.
// - index 00 read returns enables plus write-trap and read-trap flags.
// - index 01 mask; a zero mask bit drops that bit from data compare.
// - index 02 is ROM address low or memory address; 03 is high or data.
// - control 00h disables trapping; 01h traps on the ROM fetch address.
// - control 12h traps a memory read at the index 02 address.
// - 0Ch traps masked-data writes, 1Ch masked-data reads or writes.
// - 16h, 0Eh, 1Eh trap only on address and masked data both matching.
// - control 80h single-steps, trapping after every instruction.
// - read-only irq source register shows eight pending request sources.
// - ps/2 write bit 0 loads the output shift register, bit 1 shifts it.
// - ps/2 bit 2 inverts keyboard clock; bit 3 resets input register, gates clock.
// - writing zero to ps/2 bits 4-6 clears the three interrupt flags.
// - ps/2 read gives clock, data, buffer full flags and the three interrupt flags.
module ccrg_top #(
    parameter CW = 16 // timer count width
) (
    input wire pclk, // 25 MHz clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped address
    input wire [15:0] rom_addr, // cpu rom fetch address
    input wire rom_fetch, // rom fetch strobe
    input wire [7:0] rom_data_in, // data from program rom
    output wire [7:0] rom_data_out, // rom data seen by cpu
    output wire [1:0] rom_wait_states, // wait states on rom access
    input wire [7:0] mem_addr, // internal memory address
    input wire [7:0] mem_data, // internal memory data
    input wire mem_rd, // memory read strobe
    input wire mem_wr, // memory write strobe
    input wire insn_done, // instruction completed pulse
    output wire [7:0] gpio_addr_out, // memory address onto port pins
    output wire gpio_addr_oe, // port pins driven by address bus
    output reg debug_trap, // debug trap pulse
    output wire serial_dbg_irq, // serial interrupt raised by debug
    output wire en_serial, // serial port enable
    output wire en_mouse, // ps/2 mouse enable
    output wire en_hub, // hub function enable
    output wire en_serial_interface_engine, // serial interface engine enable
    output wire en_timer, // on-chip timer enable
    output wire en_keyboard, // ps/2 keyboard enable
    input wire [6:0] irq_ext, // other pending sources, bits 1-7
    input wire kbd_clk_in, // keyboard clock line
    input wire kbd_data_in, // keyboard data line
    input wire obuf_full, // output buffer full status
    input wire ibuf_full, // input buffer full status
    input wire data_port_write_ev, // host wrote data port
    input wire command_port_write_ev, // host wrote command port
    input wire kbd_send_ev, // keyboard send event
    output wire kbd_clk_eff, // keyboard clock after invert and gate
    output reg kbd_out_load, // output shift register load pulse
    output reg kbd_out_shift, // output shift register shift pulse
    output reg kbd_in_rst, // input shift register reset pulse
    output wire data_port_write_irq, // data port write interrupt
    output wire command_port_write_irq, // command port write interrupt
    output wire kbd_send_irq // keyboard send interrupt
);
    reg [CW-1:0] cnt_r;
    reg [7:0] presc_r;
    reg [7:0] pre_cnt_r;
    wire [7:0] ctl_lo_r;
    wire [7:0] ctl_hi_r;
    reg ctl_sel_r;
    reg [7:0] dbg_idx_r;
    wire [7:0] dbg_q [0:3];
    wire [7:0] dbg_ctl_r = dbg_q[0];
    wire [7:0] dbg_mask_r = dbg_q[1];
    wire [7:0] dbg_a_r = dbg_q[2];
    wire [7:0] dbg_d_r = dbg_q[3];
    wire [1:0] trap_flag_r;
    wire trap_wr_r = trap_flag_r[0];
    wire trap_rd_r = trap_flag_r[1];
    wire tmr_irq_r;
    reg kbd_inv_r;
    reg kbd_gate_r;
    wire [2:0] kirq_r;
    reg [7:0] rd_byte;
    reg [31:0] prdata_r;
    reg mapped;
    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire [7:0] wb = pwdata[7:0];
    wire [11:0] idx = {2'b00, paddr[11:2]};
    wire pre_tick;
    wire addr_hit;
    wire data_hit;
    wire rom_hit;
    wire mem_trap;
    wire mem_cyc;
    // write strobes decoded once, shared by the flag banks below
    wire wr_cnt = wr_en & ((idx == `CCRG_OFF_CNT_LO) | (idx == `CCRG_OFF_CNT_HI));
    wire wr_ctl = wr_en & (idx == `CCRG_OFF_CTL);
    wire wr_dbg = wr_en & (idx == `CCRG_OFF_DBG_DATA);
    wire wr_dbg_ctl = wr_dbg & (dbg_idx_r == `CCRG_DBG_CTL);
    wire wr_kbd = wr_en & (idx == `CCRG_OFF_KBD_CTL);
    wire tmr_last;
    wire rd_cyc;
    wire wr_cyc;
    wire step_hit;
    wire [1:0] trap_set;
    wire [2:0] kirq_set;
    wire [2:0] kirq_clr;
    localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
    localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

    // single-cycle access: the slave answers in the first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;

    always @* begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        if (idx == `CCRG_OFF_CNT_LO) begin
            rd_byte = cnt_r[7:0];
        end else if (idx == `CCRG_OFF_CNT_HI) begin
            rd_byte = cnt_r[15:8];
        end else if (idx == `CCRG_OFF_PRESC) begin
            rd_byte = presc_r;
        end else if (idx == `CCRG_OFF_CTL) begin
            rd_byte = 8'h00; // write-only register reads zero
        end else if (idx == `CCRG_OFF_CTL_SEL) begin
            rd_byte = {7'h00, ctl_sel_r};
        end else if (idx == `CCRG_OFF_DBG_IDX) begin
            rd_byte = dbg_idx_r;
        end else if (idx == `CCRG_OFF_DBG_DATA) begin
            if (dbg_idx_r == `CCRG_DBG_CTL) begin
                rd_byte = {dbg_ctl_r[7], trap_rd_r, trap_wr_r, dbg_ctl_r[4:0]};
            end else if (dbg_idx_r == `CCRG_DBG_MASK) begin
                rd_byte = dbg_mask_r;
            end else if (dbg_idx_r == `CCRG_DBG_ADDR) begin
                rd_byte = dbg_a_r;
            end else if (dbg_idx_r == `CCRG_DBG_DATA) begin
                rd_byte = dbg_d_r;
            end
        end else if (idx == `CCRG_OFF_IRQ_SRC) begin
            rd_byte = {irq_ext, tmr_irq_r};
        end else if (idx == `CCRG_OFF_KBD_CTL) begin
            rd_byte = {1'b0, kirq_r, ibuf_full, obuf_full, kbd_data_in, kbd_clk_in};
        end else begin
            mapped = 1'b0;
        end
    end

    // prescaler: one tick every presc+1 cycles while timer is enabled
    assign pre_tick = en_timer & (pre_cnt_r == presc_r);

    // reloading the count acknowledges the timer flag; a tick in that cycle still wins
    assign tmr_last = pre_tick & (cnt_r == CNT_ONE);
    ccrg_sticky #(
        .W(1)
    ) tmr_flag_i (
        .clk(pclk), // clock
        .rst_n(presetn), // reset
        .set(tmr_last), // 1 to 0 step
        .clr(wr_cnt), // count reload
        .q(tmr_irq_r) // irq source bit 0
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= `CCRG_RST_CNT;
            presc_r <= `CCRG_RST_BYTE;
            pre_cnt_r <= `CCRG_RST_BYTE;
        end else begin
            if (!en_timer || pre_tick) begin
                pre_cnt_r <= 8'h00;
            end else begin
                pre_cnt_r <= pre_cnt_r + 8'h01;
            end
            if (pre_tick && cnt_r != CNT_ZERO) begin
                cnt_r <= cnt_r - CNT_ONE;
            end
            if (wr_en && idx == `CCRG_OFF_CNT_LO) begin
                cnt_r[7:0] <= wb;
            end
            if (wr_en && idx == `CCRG_OFF_CNT_HI) begin
                cnt_r[15:8] <= wb;
            end
            if (wr_en && idx == `CCRG_OFF_PRESC) begin
                presc_r <= wb;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_sel_r <= 1'b0;
            dbg_idx_r <= `CCRG_RST_BYTE;
        end else if (wr_en) begin
            if (idx == `CCRG_OFF_CTL_SEL) begin
                ctl_sel_r <= wb[0];
            end else if (idx == `CCRG_OFF_DBG_IDX) begin
                dbg_idx_r <= wb;
            end
        end
    end

    // the shared write address is steered by the select bit at CDh
    ccrg_byte_reg ctl_lo_i (
        .clk(pclk), // clock
        .rst_n(presetn), // reset
        .we(wr_ctl & ~ctl_sel_r),
        .d(wb), // write byte
        .q(ctl_lo_r) // low control
    );
    ccrg_byte_reg ctl_hi_i (
        .clk(pclk), // clock
        .rst_n(presetn), // reset
        .we(wr_ctl & ctl_sel_r),
        .d(wb), // write byte
        .q(ctl_hi_r) // high control
    );

    // debugger registers picked by the index; indexes above 03 write nothing
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_dbg
            localparam [7:0] SEL = gi;
            ccrg_byte_reg dbg_reg_i (
                .clk(pclk), // clock
                .rst_n(presetn), // reset
                .we(wr_dbg & (dbg_idx_r == SEL)),
                .d(wb), // write byte
                .q(dbg_q[gi]) // stored byte
            );
        end
    endgenerate

    // trap matching: enables combine so 12h/0Ch/1Ch/16h/0Eh/1Eh all fall out
    assign rom_hit = dbg_ctl_r[`CCRG_TE_ROM] & rom_fetch & (rom_addr == {dbg_d_r, dbg_a_r});
    assign addr_hit = ~dbg_ctl_r[`CCRG_TE_MADDR] | (mem_addr == dbg_a_r);
    assign data_hit = ~dbg_ctl_r[`CCRG_TE_MDATA] |
        (((mem_data ^ dbg_d_r) & dbg_mask_r) == 8'h00);
    assign rd_cyc = dbg_ctl_r[`CCRG_TE_RD] & mem_rd;
    assign wr_cyc = dbg_ctl_r[`CCRG_TE_WR] & mem_wr;
    assign mem_cyc = rd_cyc | wr_cyc;
    // with neither address nor data enabled a bare cycle must not trap (00h stays silent)
    assign mem_trap = mem_cyc & (dbg_ctl_r[`CCRG_TE_MADDR] | dbg_ctl_r[`CCRG_TE_MDATA]) &
        addr_hit & data_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_trap <= 1'b0;
        end else begin
            debug_trap <= rom_hit | mem_trap | step_hit;
        end
    end

    assign step_hit = dbg_ctl_r[`CCRG_TE_STEP] & insn_done;
    // a flag names only an enabled cycle type, even if both strobes rise together
    assign trap_set = {mem_trap & rd_cyc, mem_trap & wr_cyc};
    ccrg_sticky #(
        .W(2)
    ) trap_flag_i (
        .clk(pclk), // clock
        .rst_n(presetn), // reset
        .set(trap_set), // trap cycle type
        .clr({2{wr_dbg_ctl}}), // control rewrite clears both
        .q(trap_flag_r) // read-back bits 6:5
    );

    assign serial_dbg_irq = ctl_lo_r[`CCRG_CL_DBG_SER] & debug_trap;
    assign rom_data_out = ctl_lo_r[`CCRG_CL_NOP] ? `CCRG_NOP_OPCODE : rom_data_in;
    assign gpio_addr_oe = ctl_lo_r[`CCRG_CL_ADDR_OUT];
    assign gpio_addr_out = ctl_lo_r[`CCRG_CL_ADDR_OUT] ? mem_addr : 8'h00;
    assign en_serial = ctl_hi_r[`CCRG_CH_SER];
    assign en_mouse = ctl_hi_r[`CCRG_CH_MOUSE];
    assign en_hub = ctl_hi_r[`CCRG_CH_HUB];
    assign en_serial_interface_engine = ctl_hi_r[`CCRG_CH_SIE];
    assign en_timer = ctl_hi_r[`CCRG_CH_TMR];
    assign en_keyboard = ctl_hi_r[`CCRG_CH_KBD];
    assign rom_wait_states = ctl_hi_r[`CCRG_CH_WS_HI:`CCRG_CH_WS_LO];

    // ps/2 port: an event in the clearing cycle wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kbd_inv_r <= 1'b0;
            kbd_gate_r <= 1'b0;
            kbd_out_load <= 1'b0;
            kbd_out_shift <= 1'b0;
            kbd_in_rst <= 1'b0;
        end else begin
            kbd_out_load <= wr_en & (idx == `CCRG_OFF_KBD_CTL) & wb[`CCRG_KW_LOAD];
            kbd_out_shift <= wr_en & (idx == `CCRG_OFF_KBD_CTL) & wb[`CCRG_KW_SHIFT];
            kbd_in_rst <= wr_en & (idx == `CCRG_OFF_KBD_CTL) & wb[`CCRG_KW_IN_RST];
            if (wr_kbd) begin
                kbd_inv_r <= wb[`CCRG_KW_CLK_INV];
                kbd_gate_r <= wb[`CCRG_KW_IN_RST];
            end
        end
    end

    assign kirq_set = {kbd_send_ev, command_port_write_ev, data_port_write_ev};
    assign kirq_clr = wr_kbd ? ~wb[`CCRG_KW_SEND:`CCRG_KW_DPW] : 3'b000;
    ccrg_sticky #(
        .W(3)
    ) kirq_i (
        .clk(pclk), // clock
        .rst_n(presetn), // reset
        .set(kirq_set), // port events
        .clr(kirq_clr), // written zeros
        .q(kirq_r) // interrupt flags
    );

    assign kbd_clk_eff = ~kbd_gate_r & (kbd_clk_in ^ kbd_inv_r);
    assign data_port_write_irq = kirq_r[0];
    assign command_port_write_irq = kirq_r[1];
    assign kbd_send_irq = kirq_r[2];

    // read data registered in the setup phase so prdata comes from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= {24'h000000, rd_byte};
        end
    end
endmodule // ccrg_top

// bank of sticky flags: a set in the clearing cycle wins, so no event is lost
module ccrg_sticky #(
    parameter W = 1 // number of flags
) (
    input wire clk, // clock
    input wire rst_n, // async reset, active low
    input wire [W-1:0] set, // event pulses
    input wire [W-1:0] clr, // clear requests
    output reg [W-1:0] q // flag levels
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= {W{1'b0}};
        end else begin
            q <= set | (q & ~clr);
        end
    end
endmodule // ccrg_sticky

// one byte of storage with a write strobe
module ccrg_byte_reg (
    input wire clk, // clock
    input wire rst_n, // async reset, active low
    input wire we, // write strobe
    input wire [7:0] d, // write byte
    output reg [7:0] q // stored byte
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= `CCRG_RST_BYTE;
        end else if (we) begin
            q <= d;
        end
    end
endmodule // ccrg_byte_reg
`default_nettype wire

// [ccrg_map.vh]
// register offsets, field positions and reset values of the chip control register group
`ifndef CCRG_MAP_VH
`define CCRG_MAP_VH
`define CCRG_OFF_CNT_LO 12'h0B1
`define CCRG_OFF_CNT_HI 12'h0B2
`define CCRG_OFF_PRESC 12'h0B8
`define CCRG_OFF_CTL 12'h0CC
`define CCRG_OFF_CTL_SEL 12'h0CD
`define CCRG_OFF_DBG_IDX 12'h0CE
`define CCRG_OFF_DBG_DATA 12'h0CF
`define CCRG_OFF_IRQ_SRC 12'h0DF
`define CCRG_OFF_KBD_CTL 12'h0F4
`define CCRG_BYTE_ADDR(i) ({(i), 2'b00})
`define CCRG_DBG_CTL 8'h00
`define CCRG_DBG_MASK 8'h01
`define CCRG_DBG_ADDR 8'h02
`define CCRG_DBG_DATA 8'h03
`define CCRG_TE_ROM 0
`define CCRG_TE_MADDR 1
`define CCRG_TE_MDATA 2
`define CCRG_TE_WR 3
`define CCRG_TE_RD 4
`define CCRG_TE_IO 5
`define CCRG_TE_STEP 7
`define CCRG_CL_DBG_SER 0
`define CCRG_CL_NOP 1
`define CCRG_CL_ADDR_OUT 2
`define CCRG_CH_SER 0
`define CCRG_CH_MOUSE 1
`define CCRG_CH_HUB 2
`define CCRG_CH_SIE 3
`define CCRG_CH_TMR 4
`define CCRG_CH_KBD 5
`define CCRG_CH_WS_LO 6
`define CCRG_CH_WS_HI 7
`define CCRG_KW_LOAD 0
`define CCRG_KW_SHIFT 1
`define CCRG_KW_CLK_INV 2
`define CCRG_KW_IN_RST 3
`define CCRG_KW_DPW 4
`define CCRG_KW_CPW 5
`define CCRG_KW_SEND 6
`define CCRG_RST_BYTE 8'h00
`define CCRG_RST_CNT 16'h0000
`define CCRG_NOP_OPCODE 8'h00
`endif

// [ccrg_assertions.sv]
// concurrent checks on the chip control register group ports
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_map.vh"
module ccrg_assertions (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [11:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [7:0] rom_data_in, // rom
    input wire logic [7:0] rom_data_out, // rom
    input wire logic [1:0] rom_wait_states, // rom
    input wire logic [7:0] mem_addr, // mem
    input wire logic [7:0] gpio_addr_out, // pins
    input wire logic gpio_addr_oe, // pins
    input wire logic debug_trap, // trap
    input wire logic serial_dbg_irq, // trap
    input wire logic data_port_write_ev, // ps/2
    input wire logic kbd_out_load, // ps/2
    input wire logic kbd_out_shift, // ps/2
    input wire logic data_port_write_irq // ps/2
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // either control half may move on a shared-address write, never otherwise
    wire ctl_wr = psel && penable && pwrite && paddr == 12'h330;
    sequence s_kbd_wr;
        psel && penable && pwrite && paddr == 12'h3D0;
    endsequence
    property p_ws; !$stable(rom_wait_states) |-> $past(ctl_wr); endproperty
    a_ws: assert property (p_ws) else $error("wait states moved");
    property p_oe; !$stable(gpio_addr_oe) |-> $past(ctl_wr); endproperty
    a_oe: assert property (p_oe) else $error("pin enable moved");
    property p_addr; gpio_addr_oe |-> gpio_addr_out == mem_addr; endproperty
    a_addr: assert property (p_addr) else $error("pins not showing address");
    property p_nop; rom_data_out != rom_data_in |-> rom_data_out == `CCRG_NOP_OPCODE; endproperty
    a_nop: assert property (p_nop) else $error("bad rom data");
    property p_dbg_ser; serial_dbg_irq |-> debug_trap; endproperty
    a_dbg_ser: assert property (p_dbg_ser) else $error("serial irq without trap");
    property p_load; (s_kbd_wr ##0 pwdata[0]) |=> kbd_out_load; endproperty
    a_load: assert property (p_load) else $error("no load pulse");
    property p_shift; (s_kbd_wr ##0 pwdata[1]) |=> kbd_out_shift; endproperty
    a_shift: assert property (p_shift) else $error("no shift pulse");
    property p_clr;
        (s_kbd_wr ##0 (!pwdata[4] && !data_port_write_ev)) |=> !data_port_write_irq;
    endproperty
    a_clr: assert property (p_clr) else $error("data irq not cleared");
endmodule // ccrg_assertions
bind ccrg_top ccrg_assertions ccrg_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .rom_data_in, .rom_data_out, .rom_wait_states, .mem_addr, .gpio_addr_out,
    .gpio_addr_oe, .debug_trap, .serial_dbg_irq, .data_port_write_ev, .kbd_out_load,
    .kbd_out_shift, .data_port_write_irq);
`default_nettype wire

// [tb_ccrg_top.sv]
// self-checking testbench for the chip control register group
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_map.vh"
module tb_ccrg_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rom_fetch = 0, err;
    logic mem_rd = 0, mem_wr = 0, insn_done = 0, kbd_clk_in = 0, kbd_data_in = 0, kbd_send_ev = 0;
    logic obuf_full = 0, ibuf_full = 0, data_port_write_ev = 0, command_port_write_ev = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 32'hAC342833;
    logic [15:0] rom_addr = 0;
    logic [7:0] rom_data_in = 0, mem_addr = 0, mem_data = 0;
    logic [6:0] irq_ext = 0;
    wire [31:0] prdata;
    wire [7:0] rom_data_out, gpio_addr_out;
    wire [1:0] rom_wait_states;
    wire pready, pslverr, gpio_addr_oe, debug_trap, serial_dbg_irq, en_serial, en_mouse, en_hub;
    wire en_serial_interface_engine, en_timer, en_keyboard, kbd_clk_eff, kbd_out_load;
    wire kbd_out_shift, kbd_in_rst, data_port_write_irq, command_port_write_irq, kbd_send_irq;
    wire [5:0] ens = {en_keyboard, en_timer, en_serial_interface_engine, en_hub, en_mouse, en_serial};
    int n_fail = 0, checked = 0;
    logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h12, 8'h0C, 8'h1C, 8'h16, 8'h0E, 8'h1E, 8'h80};
    logic [11:0] rw_off [4] = '{`CCRG_OFF_CNT_LO, `CCRG_OFF_CNT_HI, `CCRG_OFF_PRESC,
        `CCRG_OFF_DBG_IDX};
    ccrg_top ccrg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rom_addr, .rom_fetch, .rom_data_in, .rom_data_out, .rom_wait_states,
        .mem_addr, .mem_data, .mem_rd, .mem_wr, .insn_done, .gpio_addr_out, .gpio_addr_oe,
        .debug_trap, .serial_dbg_irq, .en_serial, .en_mouse, .en_hub, .en_serial_interface_engine,
        .en_timer, .en_keyboard, .irq_ext, .kbd_clk_in, .kbd_data_in, .obuf_full, .ibuf_full,
        .data_port_write_ev, .command_port_write_ev, .kbd_send_ev, .kbd_clk_eff,
        .kbd_out_load, .kbd_out_shift, .kbd_in_rst, .data_port_write_irq, .command_port_write_irq,
        .kbd_send_irq);
    always #20 pclk = ~pclk;
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bus master: holds the request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] off, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= off << 2;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task automatic rdchk(input logic [11:0] off, input logic [7:0] exp);
        apb(0, off, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    initial begin
        logic [7:0] v, m, a, dd, c;
        logic r, am, dm, e;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 4; i++) begin
            rdchk(rw_off[i], 8'h00);
            v = xs();
            if (i == 3) v = v & 8'h03;
            apb(1, rw_off[i], v);
            rdchk(rw_off[i], v);
        end
        apb(0, 12'h0C0, 8'h00);
        chk({pready, err}, 2'b11);
        chk(rd, 0);
        apb(1, `CCRG_OFF_CTL_SEL, 8'h01);
        for (int w = 0; w < 4; w++) begin
            v = {w[1:0], 6'(xs() & 8'h2F)}; // timer stays off here
            apb(1, `CCRG_OFF_CTL, v);
            chk(ens, v[5:0]);
            chk(rom_wait_states, v[7:6]);
        end
        apb(1, `CCRG_OFF_CTL_SEL, 8'h00);
        apb(1, `CCRG_OFF_CTL, 8'h07);
        a = xs();
        mem_addr <= a;
        rom_data_in <= 8'h3C;
        @(posedge pclk);
        #1;
        chk(gpio_addr_oe, 1'b1);
        chk(gpio_addr_out, a);
        chk(rom_data_out, `CCRG_NOP_OPCODE);
        apb(1, `CCRG_OFF_CTL, 8'h01);
        chk(gpio_addr_oe, 1'b0);
        chk(rom_data_out, 8'h3C);
        m = xs() | 8'h01; // bit 0 is the one flipped to miss
        a = xs();
        dd = xs();
        for (int i = 1; i < 4; i++) begin
            v = (i == 1) ? m : (i == 2) ? a : dd;
            apb(1, `CCRG_OFF_DBG_IDX, 8'(i));
            apb(1, `CCRG_OFF_DBG_DATA, v);
            rdchk(`CCRG_OFF_DBG_DATA, v);
        end
        foreach (codes[i]) begin
            c = codes[i];
            for (int k = 0; k < 8; k++) begin
                {dm, am, r} = 3'(k);
                apb(1, `CCRG_OFF_DBG_IDX, 8'h00);
                apb(1, `CCRG_OFF_DBG_DATA, c);
                e = c[7] | (c[0] & am & dm) | ((r ? c[4] : c[3]) & (c[1] | c[2])
                    & (am | !c[1]) & (dm | !c[2]));
                @(posedge pclk);
                {mem_rd, mem_wr, rom_fetch, insn_done} <= {r, !r, 2'b11};
                mem_addr <= am ? a : ~a;
                mem_data <= dm ? dd : dd ^ 8'h01;
                rom_addr <= {dd, (am & dm) ? a : ~a};
                @(posedge pclk);
                {mem_rd, mem_wr, rom_fetch, insn_done} <= 4'h0;
                #1;
                chk(debug_trap, e);
                chk(serial_dbg_irq, e);
                apb(0, `CCRG_OFF_DBG_DATA, 8'h00);
                chk(rd & 32'h9F, c & 8'h9F);
                if (c[7] == 1'b0 && c[0] == 1'b0) chk(rd[6:5], {e & r, e & !r});
            end
        end
        apb(1, `CCRG_OFF_PRESC, 8'h01);
        apb(1, `CCRG_OFF_CNT_LO, 8'h03);
        apb(1, `CCRG_OFF_CNT_HI, 8'h00);
        apb(1, `CCRG_OFF_CTL_SEL, 8'h01);
        apb(1, `CCRG_OFF_CTL, 8'h10);
        repeat (20) @(posedge pclk);
        rdchk(`CCRG_OFF_CNT_LO, 8'h00);
        v = xs();
        irq_ext <= v[6:0];
        rdchk(`CCRG_OFF_IRQ_SRC, {v[6:0], 1'b1});
        apb(1, `CCRG_OFF_CTL, 8'h00);
        apb(1, `CCRG_OFF_CNT_LO, 8'h05);
        rdchk(`CCRG_OFF_CNT_LO, 8'h05);
        rdchk(`CCRG_OFF_IRQ_SRC, {v[6:0], 1'b0});
        apb(1, `CCRG_OFF_KBD_CTL, 8'h7B);
        chk({kbd_in_rst, kbd_out_shift, kbd_out_load}, 3'b111);
        kbd_clk_in <= 1'b1;
        #1;
        chk(kbd_clk_eff, 1'b0);
        kbd_clk_in <= 1'b0;
        apb(1, `CCRG_OFF_KBD_CTL, 8'h74);
        chk(kbd_clk_eff, 1'b1);
        @(posedge pclk);
        {kbd_send_ev, command_port_write_ev, data_port_write_ev} <= 3'b111;
        v = xs();
        {ibuf_full, obuf_full, kbd_data_in, kbd_clk_in} <= v[3:0];
        @(posedge pclk);
        {kbd_send_ev, command_port_write_ev, data_port_write_ev} <= 3'b000;
        rdchk(`CCRG_OFF_KBD_CTL, {4'h7, v[3:0]});
        chk({kbd_send_irq, command_port_write_irq, data_port_write_irq}, 3'b111);
        apb(1, `CCRG_OFF_KBD_CTL, 8'h64);
        rdchk(`CCRG_OFF_KBD_CTL, {4'h6, v[3:0]});
        apb(1, `CCRG_OFF_KBD_CTL, 8'h00);
        rdchk(`CCRG_OFF_KBD_CTL, {4'h0, v[3:0]});
        chk({kbd_send_irq, command_port_write_irq, data_port_write_irq}, 3'b000);
        wrap_up();
    end
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
endmodule // tb_ccrg_top
`default_nettype wire
